// ### logic/dtg_pkg.sv
package dtg_pkg;

  // System clock and the crystal reference that every tone and burst time is derived from.
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned REF_HZ        = 3_579_545;
  localparam logic [28:0] CLK_HZ_W      = 29'(CLK_HZ);
  localparam logic [28:0] REF_HZ_W      = 29'(REF_HZ);

  // Tone synthesis: a period is always this many equal segments.
  localparam int unsigned SEGMENTS      = 32;
  localparam int unsigned PHASE_W       = $clog2(SEGMENTS);
  localparam int unsigned SEG_W         = 8;

  // Segment lengths in reference ticks, low group then high group.
  localparam logic [SEG_W-1:0] SEG_LEN_L1 = 8'ha0;
  localparam logic [SEG_W-1:0] SEG_LEN_L2 = 8'h92;
  localparam logic [SEG_W-1:0] SEG_LEN_L3 = 8'h84;
  localparam logic [SEG_W-1:0] SEG_LEN_L4 = 8'h76;
  localparam logic [SEG_W-1:0] SEG_LEN_H1 = 8'h5c;
  localparam logic [SEG_W-1:0] SEG_LEN_H2 = 8'h54;
  localparam logic [SEG_W-1:0] SEG_LEN_H3 = 8'h4c;
  localparam logic [SEG_W-1:0] SEG_LEN_H4 = 8'h44;

  // Quarter sine, magnitude out of 127, for segments 0 to 8 of 32.
  localparam logic [6:0] SINE_QTR [0:8] = '{7'h00, 7'h19, 7'h31, 7'h47, 7'h5a, 7'h6a, 7'h75, 7'h7d, 7'h7f};
  localparam logic [7:0] SINE_MID       = 8'h80;

  // Burst and guard times in milliseconds, then in reference ticks (rounded down).
  localparam int unsigned BURST_MS      = 51;
  localparam int unsigned GUARD_MS      = 20;
  localparam int unsigned CNT_W         = 20;
  localparam logic [CNT_W-1:0] BURST_TICKS = CNT_W'(REF_HZ * BURST_MS / 1000);
  localparam logic [CNT_W-1:0] GUARD_TICKS = CNT_W'(REF_HZ * GUARD_MS / 1000);

  // Wishbone register byte offsets.
  localparam logic [7:0] ADDR_DATA      = 8'h00;
  localparam logic [7:0] ADDR_CTRL      = 8'h04;
  localparam logic [7:0] ADDR_STAT      = 8'h08;

  // Control register fields.
  localparam int unsigned CTRL_W        = 5;
  localparam int unsigned CTRL_TX_EN    = 0;
  localparam int unsigned CTRL_BURST    = 1;
  localparam int unsigned CTRL_CP       = 2;
  localparam int unsigned CTRL_IRQ_EN   = 3;
  localparam int unsigned CTRL_RX_EN    = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h10;

  // Status register fields.
  localparam int unsigned STAT_IRQ      = 0;
  localparam int unsigned STAT_TX_RDY   = 1;
  localparam int unsigned STAT_RX_FULL  = 2;
  localparam int unsigned STAT_DSTEER_N = 3;

  // Transmit burst sequencer states.
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_BURST = 3'b010,
    TX_PAUSE = 3'b100
  } dtg_tx_state_t;

endpackage

// ### logic/dtg_tone_burst_generator.sv
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
// How it works
// - A transmit data write latches the 4-bit code and makes a 2-of-8 row/column selection.
// - Every tone period is 32 equal segments; only segment length sets frequency.
// - Segment divider counts to the code's terminal value, pulses, then restarts.
// - Each divider pulse advances a phase counter addressing the sine table.
// - Row and column chains run side by side and their samples are summed.
// - All sixteen pairs from 697/770/852/941 and 1209/1336/1477/1633 Hz are available.
// - Everything is timed from one 3.579545 MHz reference tick.
// - Burst mode sends a 51 ms tone then an equal 51 ms pause.
// - Transmitter-ready sets once the burst and its pause are finished.
// - Call-progress mode doubles burst and pause to 102 ms.
// - Call-progress plus burst mode transmits only, registering no received pairs.
// - Call-progress mode blocks signalling pair detection; call-progress tones only then.
// - In call-progress mode the shared output carries the in-band square wave, else low.
// - Too-short pairs leave receive data alone; validated pairs latch their code.
// - Receive data holds its last code until the next valid pair.
// - Dropouts shorter than the absence guard change neither data nor steering.
// - Status bit 3 shows delayed steering, low while a valid signal stands.
// - Status bit 2 sets on new received data and clears on status read.
// - Interrupt asserts on new received data and releases on status read.
// - Codes 1-9 binary, 0=1010, star=1011, hash=1100, A-C=1101-1111, D=0000.
// - Early detect follows two valid tones present, dropping as soon as lost.
module dtg_tone_burst_generator
  import dtg_pkg::*;
#(
  parameter logic [dtg_pkg::CNT_W-1:0] BURST_TICKS_P = dtg_pkg::BURST_TICKS,
  parameter logic [dtg_pkg::CNT_W-1:0] GUARD_TICKS_P = dtg_pkg::GUARD_TICKS
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        tone_pair_present_i,
  input  wire logic [3:0]  tone_pair_code_i,
  input  wire logic        cp_in_band_i,
  input  wire logic        cp_limited_i,
  output logic      [8:0]  tone_sample_o,
  output logic             tone_active_o,
  output logic             early_tone_detect_o,
  output logic             steering_guard_output_o,
  output logic      [3:0]  rx_code_bits_o,
  output logic             irq_or_tone_square_out_o
);
  import dtg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Digit code to {row, column} indices.
  function automatic logic [3:0] code_to_rc(input logic [3:0] code);
    logic [3:0] rc;
    rc = 4'hf;
    case (code)
      4'h1: rc = 4'h0;
      4'h2: rc = 4'h1;
      4'h3: rc = 4'h2;
      4'h4: rc = 4'h4;
      4'h5: rc = 4'h5;
      4'h6: rc = 4'h6;
      4'h7: rc = 4'h8;
      4'h8: rc = 4'h9;
      4'h9: rc = 4'ha;
      4'ha: rc = 4'hd;
      4'hb: rc = 4'hc;
      4'hc: rc = 4'he;
      4'hd: rc = 4'h3;
      4'he: rc = 4'h7;
      4'hf: rc = 4'hb;
      default: rc = 4'hf;
    endcase
    return rc;
  endfunction

  // Segment length for one group, picked by a one-hot nibble of the 2-of-8 selection.
  function automatic logic [SEG_W-1:0] seg_len(input logic high, input logic [3:0] onehot);
    logic [SEG_W-1:0] len;
    len = high ? SEG_LEN_H4 : SEG_LEN_L4;
    case (onehot)
      4'h1: len = high ? SEG_LEN_H1 : SEG_LEN_L1;
      4'h2: len = high ? SEG_LEN_H2 : SEG_LEN_L2;
      4'h4: len = high ? SEG_LEN_H3 : SEG_LEN_L3;
      default: len = high ? SEG_LEN_H4 : SEG_LEN_L4;
    endcase
    return len;
  endfunction

  // Sine lookup from a 32-step phase, offset binary around mid-scale.
  function automatic logic [7:0] sine_at(input logic [PHASE_W-1:0] ph);
    logic [3:0] idx;
    logic [6:0] mag;
    idx = ph[3] ? 4'(4'h8 - {1'b0, ph[2:0]}) : {1'b0, ph[2:0]};
    mag = SINE_QTR[idx];
    return ph[4] ? 8'(SINE_MID - {1'b0, mag}) : 8'(SINE_MID + {1'b0, mag});
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Reference tick: a fractional accumulator turns the fast clock into 3.579545 MHz.

  logic [28:0] ref_acc_reg, ref_acc_next;
  logic        ref_tick_reg, ref_tick_next;

  // The tick carries ref-tick jitter of one fast clock, far below any tone or burst tolerance.
  always_comb begin
    ref_acc_next  = 29'(ref_acc_reg + REF_HZ_W);
    ref_tick_next = 1'b0;
    if (ref_acc_next >= CLK_HZ_W) begin
      ref_acc_next  = 29'(ref_acc_next - CLK_HZ_W);
      ref_tick_next = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_acc_reg  <= '0;
      ref_tick_reg <= 1'b0;
    end else begin
      ref_acc_reg  <= ref_acc_next;
      ref_tick_reg <= ref_tick_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave and registers.

  logic              ack_reg, ack_next;
  logic [31:0]       dat_reg, dat_next;
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [3:0]        tx_code_reg, tx_code_next;
  logic [7:0]        tx_sel_reg, tx_sel_next;
  logic              tx_write;
  logic              stat_read;
  logic              rx_full_reg, rx_full_next;
  logic              irq_pend_reg, irq_pend_next;
  logic              tx_rdy_reg;
  logic              dsteer_reg;
  logic              rx_latch;
  logic [3:0]        rx_code_reg;
  logic [3:0]        rc;

  // Ack comes one cycle after the request is seen; the write and any read side effect happen
  // on the edge where the master samples ack, so an abandoned request leaves no trace.
  always_comb begin
    ack_next     = wb_cyc_i & wb_stb_i & ~ack_reg;
    dat_next     = dat_reg;
    ctrl_next    = ctrl_reg;
    tx_code_next = tx_code_reg;
    tx_sel_next  = tx_sel_reg;
    tx_write     = 1'b0;
    stat_read    = 1'b0;
    rc           = code_to_rc(wb_dat_i[3:0]);
    if (ack_next) begin
      dat_next = '0;
      case (wb_adr_i)
        ADDR_DATA: dat_next[3:0] = rx_code_reg;
        ADDR_CTRL: dat_next[CTRL_W-1:0] = ctrl_reg;
        ADDR_STAT: begin
          dat_next[STAT_IRQ]      = irq_pend_reg;
          dat_next[STAT_TX_RDY]   = tx_rdy_reg;
          dat_next[STAT_RX_FULL]  = rx_full_reg;
          dat_next[STAT_DSTEER_N] = ~dsteer_reg;
        end
        default: dat_next = '0;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && ack_reg) begin
      if (wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_DATA) begin
        tx_write     = 1'b1;
        tx_code_next = wb_dat_i[3:0];
        tx_sel_next  = {4'(4'h1 << rc[3:2]), 4'(4'h1 << rc[1:0])};
      end
      if (wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CTRL) begin
        ctrl_next = wb_dat_i[CTRL_W-1:0];
      end
      if (!wb_we_i && wb_adr_i == ADDR_STAT) begin
        stat_read = 1'b1;
      end
    end
    // A new received code in the same edge as a status read keeps its flags.
    rx_full_next  = rx_latch | (rx_full_reg & ~stat_read);
    irq_pend_next = rx_latch | (irq_pend_reg & ~stat_read);
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_reg      <= 1'b0;
      dat_reg      <= '0;
      ctrl_reg     <= CTRL_RESET;
      tx_code_reg  <= '0;
      tx_sel_reg   <= '0;
      rx_full_reg  <= 1'b0;
      irq_pend_reg <= 1'b0;
    end else begin
      ack_reg      <= ack_next;
      dat_reg      <= dat_next;
      ctrl_reg     <= ctrl_next;
      tx_code_reg  <= tx_code_next;
      tx_sel_reg   <= tx_sel_next;
      rx_full_reg  <= rx_full_next;
      irq_pend_reg <= irq_pend_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Burst sequencer.

  dtg_tx_state_t    tx_state_reg, tx_state_next;
  logic [CNT_W-1:0] burst_cnt_reg, burst_cnt_next;
  logic [CNT_W-1:0] burst_len;
  logic             tx_rdy_next;
  logic             tone_on;
  logic             cp_mode;
  logic             burst_mode;

  assign cp_mode    = ctrl_reg[CTRL_CP];
  assign burst_mode = ctrl_reg[CTRL_BURST];

  // Call-progress mode doubles both halves; the length is sampled at every tick so a mode
  // change mid-burst takes effect on the running interval.
  always_comb begin
    burst_len      = cp_mode ? CNT_W'({BURST_TICKS_P, 1'b0}) : BURST_TICKS_P;
    tx_state_next  = tx_state_reg;
    burst_cnt_next = burst_cnt_reg;
    tx_rdy_next    = tx_rdy_reg;
    case (tx_state_reg)
      TX_IDLE: begin
        if (!burst_mode) begin
          tx_rdy_next = 1'b1;
        end
      end
      TX_BURST, TX_PAUSE: begin
        if (ref_tick_reg) begin
          burst_cnt_next = CNT_W'(burst_cnt_reg + 1'b1);
          if (burst_cnt_next >= burst_len) begin
            burst_cnt_next = '0;
            if (tx_state_reg == TX_BURST) begin
              tx_state_next = TX_PAUSE;
            end else begin
              tx_state_next = TX_IDLE;
              tx_rdy_next   = 1'b1;
            end
          end
        end
        if (!burst_mode) begin
          tx_state_next  = TX_IDLE;
          burst_cnt_next = '0;
          tx_rdy_next    = 1'b1;
        end
      end
      default: begin
        tx_state_next  = TX_IDLE;
        burst_cnt_next = '0;
      end
    endcase
    if (tx_write && burst_mode) begin
      tx_state_next  = TX_BURST;
      burst_cnt_next = '0;
      tx_rdy_next    = 1'b0;
    end
    // With burst mode off the host gates the tone with the enable bit and its own timer.
    tone_on = burst_mode ? (tx_state_reg == TX_BURST) : ctrl_reg[CTRL_TX_EN];
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_state_reg  <= TX_IDLE;
      burst_cnt_reg <= '0;
      tx_rdy_reg    <= 1'b1;
    end else begin
      tx_state_reg  <= tx_state_next;
      burst_cnt_reg <= burst_cnt_next;
      tx_rdy_reg    <= tx_rdy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two tone chains: index 0 is the row group, index 1 the column group.

  logic [SEG_W-1:0]   seg_cnt_reg [0:1];
  logic [SEG_W-1:0]   seg_cnt_next [0:1];
  logic [PHASE_W-1:0] phase_reg [0:1];
  logic [PHASE_W-1:0] phase_next [0:1];
  logic [8:0]         sample_reg, sample_next;
  logic               tone_active_reg;
  logic [SEG_W-1:0]   term;

  // Phase restarts at zero when the tone stops, so every burst begins at the same point.
  always_comb begin
    term = '0;
    for (int g = 0; g < 2; g++) begin
      seg_cnt_next[g] = seg_cnt_reg[g];
      phase_next[g]   = phase_reg[g];
      term = seg_len(g[0], g[0] ? tx_sel_reg[3:0] : tx_sel_reg[7:4]);
      if (!tone_on) begin
        seg_cnt_next[g] = '0;
        phase_next[g]   = '0;
      end else if (ref_tick_reg) begin
        if (seg_cnt_reg[g] >= SEG_W'(term - 1'b1)) begin
          seg_cnt_next[g] = '0;
          phase_next[g]   = PHASE_W'(phase_reg[g] + 1'b1);
        end else begin
          seg_cnt_next[g] = SEG_W'(seg_cnt_reg[g] + 1'b1);
        end
      end
    end
    sample_next = tone_on ? 9'({1'b0, sine_at(phase_reg[0])} + {1'b0, sine_at(phase_reg[1])})
                          : {SINE_MID, 1'b0};
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int g = 0; g < 2; g++) begin
        seg_cnt_reg[g] <= '0;
        phase_reg[g]   <= '0;
      end
      sample_reg      <= {SINE_MID, 1'b0};
      tone_active_reg <= 1'b0;
    end else begin
      for (int g = 0; g < 2; g++) begin
        seg_cnt_reg[g] <= seg_cnt_next[g];
        phase_reg[g]   <= phase_next[g];
      end
      sample_reg      <= sample_next;
      tone_active_reg <= tone_on;
    end
  end

  assign tone_sample_o = sample_reg;
  assign tone_active_o = tone_active_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive steering: digital guard timers stand in for the external RC network.

  logic             early_reg, early_next;
  logic             dsteer_next;
  logic [CNT_W-1:0] guard_cnt_reg, guard_cnt_next;
  logic [3:0]       rx_code_next;
  logic             shared_out_reg, shared_out_next;

  // The guard counter runs toward a state change and restarts whenever the early signal
  // agrees with the steering state again, which is what makes short dropouts harmless.
  always_comb begin
    early_next     = tone_pair_present_i & ~cp_mode & ctrl_reg[CTRL_RX_EN];
    dsteer_next    = dsteer_reg;
    guard_cnt_next = guard_cnt_reg;
    rx_code_next   = rx_code_reg;
    rx_latch       = 1'b0;
    if (early_reg == dsteer_reg) begin
      guard_cnt_next = '0;
    end else if (ref_tick_reg) begin
      guard_cnt_next = CNT_W'(guard_cnt_reg + 1'b1);
      if (guard_cnt_next >= GUARD_TICKS_P) begin
        guard_cnt_next = '0;
        dsteer_next    = early_reg;
        if (early_reg) begin
          rx_code_next = tone_pair_code_i;
          rx_latch     = 1'b1;
        end
      end
    end
    // Call-progress mode shows the limited tone only when it lies in the accept band.
    shared_out_next = cp_mode ? (cp_in_band_i & cp_limited_i)
                              : (ctrl_reg[CTRL_IRQ_EN] & irq_pend_next);
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      early_reg      <= 1'b0;
      dsteer_reg     <= 1'b0;
      guard_cnt_reg  <= '0;
      rx_code_reg    <= '0;
      shared_out_reg <= 1'b0;
    end else begin
      early_reg      <= early_next;
      dsteer_reg     <= dsteer_next;
      guard_cnt_reg  <= guard_cnt_next;
      rx_code_reg    <= rx_code_next;
      shared_out_reg <= shared_out_next;
    end
  end

  assign early_tone_detect_o      = early_reg;
  assign steering_guard_output_o  = dsteer_reg;
  assign rx_code_bits_o           = rx_code_reg;
  assign irq_or_tone_square_out_o = shared_out_reg;

endmodule

// ### verification/dtg_tone_burst_generator_checker.sv
`timescale 1ns/1ps
module dtg_tone_burst_generator_checker (
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        tone_pair_present_i,
  input wire logic [8:0]  tone_sample_o,
  input wire logic        tone_active_o,
  input wire logic        early_tone_detect_o,
  input wire logic        steering_guard_output_o,
  input wire logic [3:0]  rx_code_bits_o,
  input wire logic        irq_or_tone_square_out_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answers: one ack per request, next edge, unused read bits zero.
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:5] == 27'h0)
    else $error("unused read bits set");
  unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i > 8'h08
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");

  ////////////////////////////////////////////////////////////////////////////////
  // Receive side: early detect drops with its cause, steering waits out the guard.
  early_drop_a: assert property (!tone_pair_present_i |=> !early_tone_detect_o)
    else $error("early detect outlived tone pair");
  rx_hold_a: assert property (!$rose(steering_guard_output_o) |-> $stable(rx_code_bits_o))
    else $error("receive code changed without steering");
  steer_rise_a: assert property ($rose(steering_guard_output_o)
    |-> $past(early_tone_detect_o, 1) && $past(early_tone_detect_o, 8)) else $error("steering rose early");
  steer_fall_a: assert property ($fell(steering_guard_output_o)
    |-> !$past(early_tone_detect_o, 1) && !$past(early_tone_detect_o, 8)) else $error("steering fell early");
  // Silence holds both chains at mid-scale, so the sum sits at twice the midpoint.
  silent_mid_a: assert property (!$past(tone_active_o, 1) && !$past(tone_active_o, 2)
    |-> tone_sample_o == 9'h100) else $error("sample moved while silent");

  digit_c: cover property ($rose(steering_guard_output_o));
  burst_c: cover property ($fell(tone_active_o));
  irq_c: cover property ($rose(irq_or_tone_square_out_o));
endmodule

bind dtg_tone_burst_generator dtg_tone_burst_generator_checker chk_i (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tone_pair_present_i(tone_pair_present_i),
  .tone_sample_o(tone_sample_o), .tone_active_o(tone_active_o), .early_tone_detect_o(early_tone_detect_o),
  .steering_guard_output_o(steering_guard_output_o), .rx_code_bits_o(rx_code_bits_o),
  .irq_or_tone_square_out_o(irq_or_tone_square_out_o));

// ### verification/dtg_tone_front_model.sv
`timescale 1ns/1ps
module dtg_tone_front_model (
  input  wire logic       mclk_i,
  input  wire logic       pair_on_i,
  input  wire logic [3:0] pair_code_i,
  input  wire logic       band_on_i,
  output logic            tone_pair_present_o,
  output logic      [3:0] tone_pair_code_o,
  output logic            cp_in_band_o,
  output logic            cp_limited_o
);
  logic [3:0] last_code = 4'h0;
  logic [2:0] sq_cnt    = 3'h0;

  // The limiter runs whatever the band, as a real comparator would.
  always @(posedge mclk_i) begin
    sq_cnt <= sq_cnt + 3'h1;
    if (pair_on_i) begin
      last_code <= pair_code_i;
    end
  end

  // Code lines are only valid with a pair present; otherwise they show a stale inverse.
  assign tone_pair_present_o = pair_on_i;
  assign tone_pair_code_o    = pair_on_i ? pair_code_i : ~last_code;
  assign cp_in_band_o        = band_on_i;
  assign cp_limited_o        = sq_cnt[2];
endmodule

// ### verification/tb_dtg_tone_burst_generator.sv
`timescale 1ns/1ps
module tb_dtg_tone_burst_generator;
  import dtg_pkg::*;
  localparam logic [CNT_W-1:0] BT = 20'h00064;
  localparam int TICK = 70;
  logic        mclk_i = 1'b0, reset_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [3:0]  wb_sel_i = 4'h0, pair_code = 4'h0, rx_code_bits_o, tone_pair_code_i;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        pair_on = 1'b0, band_on = 1'b0, prev, wb_ack_o, tone_pair_present_i, cp_in_band_i, cp_limited_i;
  logic        tone_active_o, early_tone_detect_o, steering_guard_output_o, irq_or_tone_square_out_o;
  logic [8:0]  tone_sample_o, smp;
  int          err_total = 0, n_compared = 0, cyc = 0, f, n, m;
  logic [3:0]  hcode [2] = '{4'h2, 4'h0};
  logic [3:0]  rcode [4] = '{4'hd, 4'h0, 4'hb, 4'hc};
  int          hseg [2] = '{int'(SEG_LEN_H2), int'(SEG_LEN_H4)};

  dtg_tone_burst_generator #(.BURST_TICKS_P(BT), .GUARD_TICKS_P(20'h00003)) DUT (.*);
  dtg_tone_front_model front (.mclk_i(mclk_i), .pair_on_i(pair_on), .pair_code_i(pair_code),
    .band_on_i(band_on), .tone_pair_present_o(tone_pair_present_i), .tone_pair_code_o(tone_pair_code_i),
    .cp_in_band_o(cp_in_band_i), .cp_limited_o(cp_limited_i));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, cycle count and a ceiling well above the planned sequence length.
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      err_total++;
      complete_run();
    end
  end

  function automatic int exp_cyc(input int ticks);
    return int'(longint'(ticks) * CLK_HZ / REF_HZ);
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic near(input string what, input int exp, input int got, input int tol);
    n_compared++;
    if (got < exp - tol || got > exp + tol) begin
      err_total++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // One classic cycle; data is taken only at the edge where ack is seen.
  task automatic acc(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] r);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge mclk_i);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    acc(1'b1, adr, d, q);
  endtask
  task automatic rd(input logic [7:0] adr, input string what, input logic [31:0] exp);
    acc(1'b0, adr, 32'h0, q);
    chk(what, exp, q);
  endtask
  // Length of the next burst and the moment the sample first leaves mid-scale.
  task automatic burst_meas(output int first, output int len);
    int t0;
    t0 = cyc;
    while (tone_active_o !== 1'b1 && cyc - t0 < 2000) @(posedge mclk_i);
    t0 = cyc;
    first = 0;
    while (tone_active_o === 1'b1 && cyc - t0 < 30000) begin
      if (first == 0 && tone_sample_o !== 9'h100) begin
        first = cyc - t0;
        smp = tone_sample_o;
      end
      @(posedge mclk_i);
    end
    len = cyc - t0;
  endtask
  task automatic pause_meas(output int len);
    int t0;
    t0 = cyc;
    q = 32'h0;
    while (q[1] !== 1'b1 && cyc - t0 < 30000) acc(1'b0, ADDR_STAT, 32'h0, q);
    len = cyc - t0;
  endtask
  task automatic pair(input logic [3:0] c, input int on_n, input int off_n);
    pair_code <= c;
    pair_on <= 1'b1;
    repeat (on_n) @(posedge mclk_i);
    pair_on <= 1'b0;
    repeat (off_n) @(posedge mclk_i);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Register defaults, refused addresses, then transmit, call-progress and receive.
  initial begin
    repeat (10) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(ADDR_CTRL, "ctrl reset", 32'h10);
    rd(ADDR_STAT, "status reset", 32'ha);
    wr(8'h0c, 32'h1f);
    rd(8'h0c, "unmapped", 32'h0);
    rd(ADDR_CTRL, "ctrl after stray write", 32'h10);
    wr(ADDR_CTRL, 32'h11);
    @(posedge mclk_i);
    chk("host keyed tone", 1, tone_active_o);
    rd(ADDR_STAT, "ready without burst", 32'ha);
    wr(ADDR_CTRL, 32'h10);
    @(posedge mclk_i);
    chk("host tone off", 0, tone_active_o);
    foreach (hcode[i]) begin
      wr(ADDR_CTRL, 32'h13);
      wr(ADDR_DATA, {28'h0, hcode[i]});
      rd(ADDR_STAT, "ready cleared", 32'h8);
      burst_meas(f, n);
      near("first segment", exp_cyc(hseg[i]), f, 2 * TICK);
      chk("first step", 9'h119, smp);
      near("burst", exp_cyc(BT) - TICK / 2, n, TICK);
      pause_meas(m);
      near("pause", exp_cyc(BT) - TICK / 2, m, TICK);
    end
    wr(ADDR_CTRL, 32'h17);
    pair_code <= 4'h9;
    pair_on <= 1'b1;
    wr(ADDR_DATA, 32'h5);
    burst_meas(f, n);
    near("cp burst", 2 * exp_cyc(BT), n, 2 * TICK);
    pause_meas(m);
    near("cp pause", 2 * exp_cyc(BT), m, 2 * TICK);
    chk("cp no early", 0, early_tone_detect_o);
    chk("cp no steering", 0, steering_guard_output_o);
    chk("cp rx kept", 0, rx_code_bits_o);
    pair_on <= 1'b0;
    band_on <= 1'b1;
    m = 0;
    prev = 1'b0;
    repeat (64) begin
      @(posedge mclk_i);
      if (irq_or_tone_square_out_o !== prev) m++;
      prev = cp_in_band_i & cp_limited_i;
    end
    chk("square mismatches", 0, m);
    band_on <= 1'b0;
    @(posedge mclk_i);
    m = 0;
    repeat (64) begin
      @(posedge mclk_i);
      if (irq_or_tone_square_out_o !== 1'b0) m++;
    end
    chk("out of band highs", 0, m);
    wr(ADDR_CTRL, 32'h18);
    pair(4'h7, 100, 400);
    chk("short pair rx", 0, rx_code_bits_o);
    rd(ADDR_STAT, "short pair status", 32'ha);
    pair_code <= 4'h7;
    pair_on <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk("early", 1, early_tone_detect_o);
    repeat (497) @(posedge mclk_i);
    chk("rx latched", 4'h7, rx_code_bits_o);
    chk("irq raised", 1, irq_or_tone_square_out_o);
    rd(ADDR_STAT, "digit status", 32'h7);
    rd(ADDR_STAT, "status cleared", 32'h2);
    chk("irq released", 0, irq_or_tone_square_out_o);
    pair(4'h7, 1, 100);
    pair(4'h7, 300, 0);
    chk("dropout steering", 1, steering_guard_output_o);
    rd(ADDR_DATA, "dropout rx", 32'h7);
    repeat (500) @(posedge mclk_i);
    pair_on <= 1'b0;
    repeat (500) @(posedge mclk_i);
    chk("rx retained", 4'h7, rx_code_bits_o);
    rd(ADDR_STAT, "after digit", 32'ha);
    foreach (rcode[i]) begin
      pair(rcode[i], 500, 500);
      rd(ADDR_DATA, "code table", {28'h0, rcode[i]});
    end
    complete_run();
  end
endmodule
